// ---- src/spc_pkg.sv ----
// Shared constants for the speech frame parameter codec.
package spc_pkg;
  // Timing: system clock, sample rate, frame length
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned SAMPLE_HZ = 8_000;
  localparam int unsigned TICK_CYC = CLK_HZ / SAMPLE_HZ;
  localparam int unsigned FRAME_MS = 20;
  localparam int unsigned FRAME_SAMPLES = SAMPLE_HZ * FRAME_MS / 1000;
  localparam int unsigned SUB_SAMPLES = 40;
  // Coded frame layout
  localparam int unsigned FRAME_WORDS = 76;
  localparam int unsigned LAR_WORDS = 8;
  localparam int unsigned SUB_WORDS = 17;
  localparam int unsigned PULSES = 13;
  localparam int unsigned SUBFRAMES = 4;
  localparam int unsigned W_LAR_TOP = 6;
  localparam int unsigned W_LAG = 7;
  localparam int unsigned W_GAIN = 2;
  localparam int unsigned W_GRID = 2;
  localparam int unsigned W_AMP = 6;
  localparam int unsigned W_PULSE = 3;
  // Subframe word positions
  localparam logic [4:0] SP_LAG = 5'h00;
  localparam logic [4:0] SP_GAIN = 5'h01;
  localparam logic [4:0] SP_GRID = 5'h02;
  localparam logic [4:0] SP_AMP = 5'h03;
  // PCM word format: 13-bit sample over 3 padding bits
  localparam int unsigned PCM_PAD = 3;
  // Lag range of an error-free channel
  localparam logic [15:0] LAG_MIN = 16'h0028;
  localparam logic [15:0] LAG_MAX = 16'h0078;
  // Log-area to reflection coefficient breakpoints
  localparam logic [15:0] RC_BRK1 = 16'h2b33;
  localparam logic [15:0] RC_BRK2 = 16'h4e66;
  localparam logic [15:0] RC_OFS = 16'h6600;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ACF = 8'h08;
  localparam logic [7:0] REG_MAXABS = 8'h0c;
  localparam logic [7:0] REG_INTERPOLATED_LOG_AREA = 8'h10;
  localparam logic [7:0] REG_RC = 8'h14;
  localparam logic [7:0] REG_CMP = 8'h18;
  localparam logic [7:0] REG_CMPRES = 8'h1c;
  // Register fields and reset values
  localparam int unsigned CTRL_DEC_EN = 0;
  localparam int unsigned CTRL_CLR = 1;
  localparam int unsigned ST_LAG = 0;
  localparam int unsigned ST_BUSY = 1;
  localparam int unsigned ST_FULL = 2;
  localparam int unsigned ST_LAG_LSB = 8;
  localparam logic CTRL_DEC_EN_RST = 1'b0;
  // AXI responses
  localparam logic [1:0] RESP_OK = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : spc_pkg

// ---- src/spc_core.sv ----
// Speech frame parameter codec: framing, checkpoints, register slave.
//
// Summary of operation
// [RL1] Encoder takes upper 13 bits of input
// [RL2] Decoder output left justified, low bits zero
// [RL3] Eight log-area codes, widths 6,6,5,5,4,4,3,3
// [RL4] Subframe: 7-bit lag, 2-bit gain, 2-bit grid
// [RL5] Then 6-bit amplitude and thirteen 3-bit pulses
// [RL6] Any lag 0..127 accepted, out-of-range flagged
// [RL7] Autocorrelation sums all 160 samples
// [RL8] Early exit only on strictly less
// [RL9] Breakpoints 11059 and 20070 used exactly
// [RL10] Scaling search covers all 40 samples
// [RL11] Frame is 76 words, 20 ms
// [RL12] Samples move at 8 kHz continuously
// [RL13] State reset sets every codec variable
// [RL14] 16-bit arithmetic saturates, never wraps; lar_to_rc wraps for magnitudes of 26624 and up
// [RL15] Frames played in order without gaps
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ns
module spc_core #(
  parameter int unsigned TICK = spc_pkg::TICK_CYC
) (
  // Clock, enable, reset
  input wire logic clk_i,
  input wire logic ce_i,
  input wire logic rst_n_i,
  // Encoder PCM input stream
  input wire logic pcm_in_valid_i,
  input wire logic [15:0] pcm_in_data_i,
  // Coded parameter input stream
  input wire logic param_valid_i,
  input wire logic [15:0] param_word_i,
  output logic param_ready_o,
  // Decoder PCM output stream
  output logic pcm_out_valid_o,
  output logic [15:0] pcm_out_data_o,
  // AXI4-Lite write channels
  input wire logic s_axi_awvalid_i,
  input wire logic [7:0] s_axi_awaddr_i,
  output logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  output logic s_axi_wready_o,
  output logic s_axi_bvalid_o,
  output logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read channels
  input wire logic s_axi_arvalid_i,
  input wire logic [7:0] s_axi_araddr_i,
  output logic s_axi_arready_o,
  output logic s_axi_rvalid_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  input wire logic s_axi_rready_i
);
  import spc_pkg::*;

  // Saturating absolute value; the most negative code maps to max
  function automatic logic [15:0] sat_abs(input logic [15:0] v);
    if (v == 16'h8000) return 16'h7fff; // RL14
    return v[15] ? 16'(-v) : v;
  endfunction : sat_abs

  // Interpolated log-area to reflection coefficient
  function automatic logic [15:0] lar_to_rc(input logic [15:0] v);
    logic [15:0] t;
    t = sat_abs(v);
    if (t < RC_BRK1) t = {t[14:0], 1'b0}; // RL9
    else if (t < RC_BRK2) t = 16'(t + RC_BRK1); // RL9
    else t = 16'((t >> 2) + RC_OFS);
    return v[15] ? 16'(-t) : t;
  endfunction : lar_to_rc

  // Merge write data under byte strobes
  function automatic logic [31:0] strb_merge(input logic [31:0] o,
      input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) if (s[b]) r[8*b +: 8] = d[8*b +: 8];
    return r;
  endfunction : strb_merge

  // Field width of word by frame position
  function automatic int unsigned fld_w(input logic lar,
      input logic [6:0] idx, input logic [4:0] sp);
    if (lar) return W_LAR_TOP - int'(idx[2:1]); // RL3
    unique case (sp)
      SP_LAG: return W_LAG; // RL4
      SP_GAIN: return W_GAIN;
      SP_GRID: return W_GRID;
      SP_AMP: return W_AMP; // RL5
      default: return W_PULSE;
    endcase
  endfunction : fld_w

  // Register state
  logic dec_en_ff; // Enables parameter intake; playback of a collected frame is not gated
  logic clr_ff; // One-cycle codec state reset from software
  logic lag_flag_ff; // Sticky: lag outside error-free range
  logic col_full_ff; // A whole frame waits for playback
  logic play_busy_ff; // Frame being played
  logic [6:0] last_lag_ff; // Most recent received_lag
  logic [31:0] acf_ff; // Zero-lag autocorrelation of last segment
  logic [15:0] maxabs_ff; // Largest magnitude in last subframe
  logic [15:0] interpolated_log_area_ff; // interpolated_log_area
  logic [31:0] cmp_ff; // Comparator operands
  logic [15:0] rc_w; // reflection_coeff view
  logic cmp_exit_w; // Early-exit decision
  logic st_clr; // Codec state clear, hardware or software

  assign st_clr = !rst_n_i || clr_ff; // RL13
  assign rc_w = lar_to_rc(interpolated_log_area_ff);
  assign cmp_exit_w = $signed({cmp_ff[15], cmp_ff[15:0]}) <
                      $signed({1'b0, sat_abs(cmp_ff[31:16])}); // RL8

  // AXI slave state
  logic aw_got_ff, w_got_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic wr_go;

  assign wr_go = aw_got_ff && w_got_ff && !s_axi_bvalid_o;

  // Write address and data taken in either order, one write at a time
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RESP_OK;
    end else if (ce_i) begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata_i;
        wstrb_ff <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      if (wr_go) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        // Unmapped or read-only offsets answer with slave error
        s_axi_bresp_o <= (awaddr_ff == REG_CTRL ||
                          awaddr_ff == REG_STATUS ||
                          awaddr_ff == REG_INTERPOLATED_LOG_AREA ||
                          awaddr_ff == REG_CMP) ? RESP_OK : RESP_SLVERR;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o <= 1'b1;
      end
    end
  end

  // Software-written registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      dec_en_ff <= CTRL_DEC_EN_RST;
      clr_ff <= 1'b0;
      interpolated_log_area_ff <= 16'h0000;
      cmp_ff <= 32'h0000_0000;
    end else if (ce_i) begin
      clr_ff <= 1'b0; // Self-clearing strobe
      if (wr_go) begin
        unique case (awaddr_ff)
          REG_CTRL: begin
            if (wstrb_ff[0]) begin
              dec_en_ff <= wdata_ff[CTRL_DEC_EN];
              clr_ff <= wdata_ff[CTRL_CLR];
            end
          end
          REG_INTERPOLATED_LOG_AREA: interpolated_log_area_ff <= 16'(strb_merge({16'h0000, interpolated_log_area_ff},
                                              wdata_ff, wstrb_ff));
          REG_CMP: cmp_ff <= strb_merge(cmp_ff, wdata_ff, wstrb_ff);
          default: ;
        endcase
      end
    end
  end

  // Read channel: data captured at address handshake
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= RESP_OK;
    end else if (ce_i) begin
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o <= 1'b1;
        s_axi_rresp_o <= RESP_OK;
        unique case (s_axi_araddr_i)
          REG_CTRL: s_axi_rdata_o <= {31'h0, dec_en_ff};
          REG_STATUS: s_axi_rdata_o <= {17'h0, last_lag_ff, 5'h0,
              col_full_ff, play_busy_ff, lag_flag_ff};
          REG_ACF: s_axi_rdata_o <= acf_ff;
          REG_MAXABS: s_axi_rdata_o <= {16'h0000, maxabs_ff};
          REG_INTERPOLATED_LOG_AREA: s_axi_rdata_o <= {16'h0000, interpolated_log_area_ff};
          REG_RC: s_axi_rdata_o <= {16'h0000, rc_w};
          REG_CMP: s_axi_rdata_o <= cmp_ff;
          REG_CMPRES: s_axi_rdata_o <= {31'h0, cmp_exit_w};
          default: begin
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
        s_axi_arready_o <= 1'b1;
      end
    end
  end

  // Encoder checkpoints: segment energy and subframe peak
  logic [7:0] eidx_ff; // Sample index within 160-sample segment
  logic [5:0] epos_ff; // Sample index within 40-sample subframe
  logic [31:0] eacc_ff; // Running sum of squares
  logic [15:0] emax_ff; // Running peak magnitude
  logic signed [12:0] esmp; // 13-bit sample
  logic [25:0] esq; // Its square
  logic [32:0] esum; // Unsaturated accumulation
  logic [15:0] eabs; // Saturated magnitude of the 16-bit view

  assign esmp = pcm_in_data_i[15:PCM_PAD]; // RL1
  assign esq = 26'(esmp * esmp);
  assign esum = {1'b0, eacc_ff} + {7'h00, esq};
  assign eabs = sat_abs({esmp, 3'b000});

  always_ff @(posedge clk_i) begin
    if (st_clr) begin
      eidx_ff <= 8'h00;
      epos_ff <= 6'h00;
      eacc_ff <= 32'h0000_0000;
      emax_ff <= 16'h0000;
      acf_ff <= 32'h0000_0000;
      maxabs_ff <= 16'h0000;
    end else if (ce_i && pcm_in_valid_i) begin
      // Saturate rather than wrap on a loud segment
      if (eidx_ff == 8'(FRAME_SAMPLES - 1)) begin
        acf_ff <= esum[32] ? 32'hffff_ffff : esum[31:0]; // RL7 RL14
        eacc_ff <= 32'h0000_0000;
        eidx_ff <= 8'h00;
      end else begin
        eacc_ff <= esum[32] ? 32'hffff_ffff : esum[31:0];
        eidx_ff <= 8'(eidx_ff + 8'h01);
      end
      if (epos_ff == 6'(SUB_SAMPLES - 1)) begin
        maxabs_ff <= (eabs > emax_ff) ? eabs : emax_ff; // RL10
        emax_ff <= 16'h0000;
        epos_ff <= 6'h00;
      end else begin
        emax_ff <= (eabs > emax_ff) ? eabs : emax_ff;
        epos_ff <= 6'(epos_ff + 6'h01);
      end
    end
  end

  // A state clear also moves these registers, so skip the edge after it
  a_acf_span: assert property (@(posedge clk_i) // RL7
    disable iff (st_clr)
    $changed(acf_ff) && !$past(st_clr) |-> $past(eidx_ff) == 8'h9f)
    else $error("segment energy latched before sample 159");
  a_peak_span: assert property (@(posedge clk_i) // RL10
    disable iff (st_clr)
    $changed(maxabs_ff) && !$past(st_clr) |-> $past(epos_ff) == 6'h27)
    else $error("subframe peak latched before sample 39");

  // Decoder intake: 76 words, each masked to its field width
  logic [6:0] widx_ff; // Word index in frame
  logic [4:0] sp_ff; // Word index in subframe
  logic [1:0] sb_ff; // Subframe number
  logic [3:0] cpi_ff; // Pulse index while collecting
  logic [15:0] last_word_ff; // Last word as accepted, masked
  logic [2:0] col_pulse [SUBFRAMES*PULSES]; // Collected pulse codes
  logic p_take, p_lar, lag_bad;
  logic [15:0] p_mask, p_word;

  assign p_take = param_valid_i && param_ready_o;
  assign p_lar = widx_ff < 7'(LAR_WORDS);
  assign p_mask = 16'((32'h1 << fld_w(p_lar, widx_ff, sp_ff)) - 32'h1);
  assign p_word = param_word_i & p_mask; // RL3 RL4 RL5
  assign lag_bad = p_word < LAG_MIN || p_word > LAG_MAX;

  always_ff @(posedge clk_i) begin
    if (st_clr) begin
      widx_ff <= 7'h00;
      sp_ff <= 5'h00;
      sb_ff <= 2'h0;
      cpi_ff <= 4'h0;
      last_word_ff <= 16'h0000;
      last_lag_ff <= 7'h00;
      for (int i = 0; i < SUBFRAMES*PULSES; i++) col_pulse[i] <= 3'h0;
    end else if (ce_i && p_take) begin
      last_word_ff <= p_word;
      if (!p_lar && sp_ff == SP_LAG) last_lag_ff <= p_word[6:0]; // RL6
      if (!p_lar && sp_ff > SP_AMP) begin
        col_pulse[sb_ff*PULSES + cpi_ff] <= p_word[2:0];
        cpi_ff <= 4'(cpi_ff + 4'h1);
      end
      if (widx_ff == 7'(FRAME_WORDS - 1)) begin
        widx_ff <= 7'h00; // RL11
        sp_ff <= 5'h00;
        sb_ff <= 2'h0;
        cpi_ff <= 4'h0;
      end else begin
        widx_ff <= 7'(widx_ff + 7'h01);
        if (!p_lar && sp_ff == 5'(SUB_WORDS - 1)) begin
          sp_ff <= 5'h00;
          sb_ff <= 2'(sb_ff + 2'h1);
          cpi_ff <= 4'h0;
        end else if (!p_lar) sp_ff <= 5'(sp_ff + 5'h01);
      end
    end
  end

  // Lag flag: every code accepted, out-of-range noted; set beats clear
  always_ff @(posedge clk_i) begin
    if (st_clr) lag_flag_ff <= 1'b0;
    else if (ce_i) begin
      if (p_take && !p_lar && sp_ff == SP_LAG && lag_bad)
        lag_flag_ff <= 1'b1; // RL6
      else if (wr_go && awaddr_ff == REG_STATUS && wstrb_ff[0] &&
               wdata_ff[ST_LAG]) lag_flag_ff <= 1'b0;
    end
  end

  a_lag_flag: assert property (@(posedge clk_i) // RL6
    disable iff (st_clr)
    ce_i && p_take && !p_lar && sp_ff == SP_LAG && p_word > LAG_MAX
    |=> lag_flag_ff)
    else $error("out-of-range lag not flagged");
  a_field_mask: assert property (@(posedge clk_i) // RL3
    disable iff (st_clr)
    ce_i && p_take && widx_ff < 7'h02 |=> last_word_ff[15:6] == 10'h000)
    else $error("log-area code wider than its field");
  a_state_clr: assert property (@(posedge clk_i) // RL13
    disable iff (!rst_n_i)
    clr_ff |=> widx_ff == 7'h00 && eidx_ff == 8'h00 && !lag_flag_ff)
    else $error("codec state not cleared by state reset");

  // Playback: 160 samples per frame, one per 8 kHz tick
  logic [10:0] tick_ff; // Sample period divider
  logic [7:0] samp_ff; // Output sample number
  logic [1:0] psub_ff; // Subframe of current sample
  logic [5:0] ppos_ff; // Position within subframe
  logic [1:0] ph_ff; // Three samples per pulse code
  logic [3:0] pidx_ff; // Pulse code index, held at last
  logic [2:0] play_pulse [SUBFRAMES*PULSES]; // Frame being played
  logic tick_w, load_w;
  logic [2:0] pcode;

  assign tick_w = tick_ff == 11'(TICK - 1); // RL12
  assign load_w = col_full_ff && !play_busy_ff;
  assign pcode = play_pulse[psub_ff*PULSES + pidx_ff];

  always_ff @(posedge clk_i) begin
    if (st_clr) tick_ff <= 11'h000;
    else if (ce_i) tick_ff <= tick_w ? 11'h000 : 11'(tick_ff + 11'h001);
  end

  // Intake ready: frames wait when the play copy is still busy
  always_ff @(posedge clk_i) begin
    if (st_clr) begin
      col_full_ff <= 1'b0;
      param_ready_o <= 1'b0;
    end else if (ce_i) begin
      if (p_take && widx_ff == 7'(FRAME_WORDS - 1)) begin
        col_full_ff <= 1'b1; // RL15
        param_ready_o <= 1'b0;
      end else if (load_w) begin
        col_full_ff <= 1'b0;
        param_ready_o <= dec_en_ff;
      end else param_ready_o <= dec_en_ff && !col_full_ff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (st_clr) begin
      play_busy_ff <= 1'b0;
      samp_ff <= 8'h00;
      psub_ff <= 2'h0;
      ppos_ff <= 6'h00;
      ph_ff <= 2'h0;
      pidx_ff <= 4'h0;
      pcm_out_valid_o <= 1'b0;
      pcm_out_data_o <= 16'h0000;
      for (int i = 0; i < SUBFRAMES*PULSES; i++) play_pulse[i] <= 3'h0;
    end else if (ce_i) begin
      pcm_out_valid_o <= 1'b0;
      if (load_w) begin
        play_pulse <= col_pulse; // RL15
        play_busy_ff <= 1'b1;
      end else if (play_busy_ff && tick_w) begin
        pcm_out_valid_o <= 1'b1;
        // Coarse level from the pulse code, padded to 16 bits
        pcm_out_data_o <= {~pcode[2], pcode[1:0], 10'h000,
                           PCM_PAD'(0)}; // RL2
        ph_ff <= (ph_ff == 2'h2) ? 2'h0 : 2'(ph_ff + 2'h1);
        if (ph_ff == 2'h2 && pidx_ff != 4'(PULSES - 1))
          pidx_ff <= 4'(pidx_ff + 4'h1);
        if (ppos_ff == 6'(SUB_SAMPLES - 1)) begin
          ppos_ff <= 6'h00;
          ph_ff <= 2'h0;
          pidx_ff <= 4'h0;
          psub_ff <= 2'(psub_ff + 2'h1);
        end else ppos_ff <= 6'(ppos_ff + 6'h01);
        if (samp_ff == 8'(FRAME_SAMPLES - 1)) begin
          samp_ff <= 8'h00;
          play_busy_ff <= 1'b0;
        end else samp_ff <= 8'(samp_ff + 8'h01);
      end
    end
  end

  a_out_pad: assert property (@(posedge clk_i) // RL2
    disable iff (st_clr)
    pcm_out_valid_o |-> pcm_out_data_o[2:0] == 3'b000)
    else $error("decoder output padding bits not zero");
  a_frame_end: assert property (@(posedge clk_i) // RL11
    disable iff (st_clr)
    ce_i && p_take && widx_ff == 7'h4b |=> !param_ready_o && col_full_ff)
    else $error("76th word did not close the frame");
  a_tick_period: assert property (@(posedge clk_i) // RL12
    disable iff (st_clr)
    ce_i && tick_w |=> tick_ff == 11'h000 || !ce_i)
    else $error("sample divider did not wrap");
  a_out_order: assert property (@(posedge clk_i) // RL15
    disable iff (st_clr)
    pcm_out_valid_o |-> samp_ff == 8'($past(samp_ff) + 8'h01) ||
    (samp_ff == 8'h00 && $past(samp_ff) == 8'h9f))
    else $error("output sample skipped or repeated");
  a_early_exit: assert property (@(posedge clk_i) // RL8
    disable iff (!rst_n_i)
    cmp_ff[15:0] == sat_abs(cmp_ff[31:16]) |-> !cmp_exit_w)
    else $error("equal operands took the early exit");
  a_rc_break: assert property (@(posedge clk_i) // RL9
    disable iff (!rst_n_i)
    interpolated_log_area_ff == RC_BRK1 |-> rc_w == 16'h5666)
    else $error("first breakpoint misplaced");
endmodule : spc_core

// ---- test/spc_partner.sv ----
// Far-side model: PCM source, coded word sender and PCM output sink.
`timescale 1ns/1ns
module spc_partner (
  // Clock
  input wire logic clk_i,
  // Encoder sample stream toward the block
  output logic pcm_in_valid_o,
  output logic [15:0] pcm_in_data_o,
  // Coded word stream toward the block
  output logic param_valid_o,
  output logic [15:0] param_word_o,
  input wire logic param_ready_i,
  // Decoder sample stream from the block
  input wire logic pcm_out_valid_i,
  input wire logic [15:0] pcm_out_data_i
);
  logic [15:0] frame [76]; // Words of the next coded frame
  logic [15:0] got [160]; // Captured decoder samples
  int got_n; // Count of samples seen
  int stalls; // Frames given up on after a long stall

  initial begin
    pcm_in_valid_o = 1'b0;
    pcm_in_data_o = 16'h0000;
    param_valid_o = 1'b0;
    param_word_o = 16'h0000;
    got_n = 0;
    stalls = 0;
  end

  // Sink keeps the first 160 decoder samples in arrival order
  always @(posedge clk_i) begin
    if (pcm_out_valid_i === 1'b1) begin
      if (got_n < 160) begin
        got[got_n] <= pcm_out_data_i;
      end
      got_n <= got_n + 1;
    end
  end

  // Forget earlier captures
  task clear_got;
    got_n = 0;
  endtask : clear_got

  // Strobed samples, left justified; idle data is scrambled
  task send_pcm(input logic [15:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      pcm_in_valid_o <= 1'b1;
      pcm_in_data_o <= v;
      @(posedge clk_i);
      pcm_in_valid_o <= 1'b0;
      pcm_in_data_o <= ~v;
    end
  endtask : send_pcm

  // All 76 words in order, each held until taken
  task send_frame;
    int k;
    @(posedge clk_i);
    for (int i = 0; i < 76; i++) begin
      param_valid_o <= 1'b1;
      param_word_o <= frame[i];
      k = 0;
      do begin
        @(posedge clk_i);
        k++;
      end while (param_ready_i !== 1'b1 && k < 2000);
      // Give up on the frame rather than hang the run
      if (param_ready_i !== 1'b1) begin
        stalls++;
        break;
      end
    end
    param_valid_o <= 1'b0;
    param_word_o <= ~frame[75];
  endtask : send_frame
endmodule : spc_partner

// ---- test/spc_core_tb.sv ----
// Self-checking bench for the speech frame parameter codec core.
`timescale 1ns/1ns
module spc_core_tb;
  import spc_pkg::*;
  logic clk_i, rst_n_i;
  logic ce; // Clock enable toward the block
  // Register bus master signals
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  // Streams between block and partner
  logic pin_v, prm_v, prm_rdy, pout_v;
  logic [15:0] pin_d, prm_w, pout_d;
  int num_errors, total_checks;

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // Short tick so a frame plays out quickly
  spc_core #(.TICK(8)) dut_u (.clk_i(clk_i), .ce_i(ce), .rst_n_i(rst_n_i),
    .pcm_in_valid_i(pin_v), .pcm_in_data_i(pin_d), .param_valid_i(prm_v),
    .param_word_i(prm_w), .param_ready_o(prm_rdy), .pcm_out_valid_o(pout_v),
    .pcm_out_data_o(pout_d), .s_axi_awvalid_i(awvalid),
    .s_axi_awaddr_i(awaddr), .s_axi_awready_o(awready),
    .s_axi_wvalid_i(wvalid), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
    .s_axi_wready_o(wready), .s_axi_bvalid_o(bvalid),
    .s_axi_bresp_o(bresp), .s_axi_bready_i(bready),
    .s_axi_arvalid_i(arvalid), .s_axi_araddr_i(araddr),
    .s_axi_arready_o(arready), .s_axi_rvalid_o(rvalid),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rready_i(rready));

  spc_partner partner_u (.clk_i(clk_i), .pcm_in_valid_o(pin_v),
    .pcm_in_data_o(pin_d), .param_valid_o(prm_v), .param_word_o(prm_w),
    .param_ready_i(prm_rdy), .pcm_out_valid_i(pout_v),
    .pcm_out_data_i(pout_d));

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task wrap_up;
    if (num_errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up

  // One write; both channels offered together, each dropped when taken
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk_i);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    bready <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 100);
    bready <= 1'b0;
    chk("bresp", {30'h0, bresp}, {30'h0, er});
    if (n >= 100) begin
      num_errors++;
      wrap_up();
    end
  endtask : wr

  // One read; rready held until the answer
  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 100) begin
      num_errors++;
      wrap_up();
    end
  endtask : rd

  // Reset values and refused accesses
  task t_regs;
    logic [31:0] d;
    logic [1:0] r;
    rd(REG_CTRL, d, r);
    chk("ctrl_rst", d, 32'h0);
    rd(REG_STATUS, d, r);
    chk("status_rst", d, 32'h0);
    rd(8'h20, d, r);
    chk("unmapped", {r, d[29:0]}, {RESP_SLVERR, 30'h0});
    wr(REG_RC, 32'h1, RESP_SLVERR);
  endtask : t_regs

  // Equal magnitude must not take the early exit
  task t_cmp;
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 4; i++) begin
      wr(REG_CMP, {((i > 1) ? 16'h0005 : 16'hfffb), 16'(5 - i % 2)}, RESP_OK);
      rd(REG_CMPRES, d, r);
      chk("early_exit", {31'h0, d[0]}, {31'h0, 1'(i % 2)});
    end
  endtask : t_cmp

  // Both sides of each breakpoint
  task t_rc;
    logic [31:0] d;
    logic [1:0] r;
    logic [15:0] lv [4];
    logic [15:0] ev [4];
    lv = '{16'd11058, 16'd11059, 16'd20069, 16'd20070};
    ev = '{16'd22116, 16'd22118, 16'd31128, 16'd31129};
    for (int i = 0; i < 4; i++) begin
      wr(REG_INTERPOLATED_LOG_AREA, {16'h0, lv[i]}, RESP_OK);
      rd(REG_RC, d, r);
      chk("rc", {16'h0, d[15:0]}, {16'h0, ev[i]});
    end
  endtask : t_rc

  // Junk low bits ignored; full-length sums; state reset; saturation
  task t_enc;
    logic [31:0] d;
    logic [1:0] r;
    partner_u.send_pcm(16'h001f, 160);
    rd(REG_ACF, d, r);
    chk("acf", d, 32'd1440);
    rd(REG_MAXABS, d, r);
    chk("maxabs", d, 32'd24);
    wr(REG_CTRL, 32'h2, RESP_OK);
    rd(REG_ACF, d, r);
    chk("acf_clr", d, 32'h0);
    // Peak sits in the last sample, so a short window would miss it
    partner_u.send_pcm(16'h001f, 39);
    partner_u.send_pcm(16'h8007, 1);
    rd(REG_MAXABS, d, r);
    chk("maxabs_sat", d, 32'h7fff);
    // Samples offered with the enable low must leave no trace
    @(posedge clk_i);
    ce <= 1'b0;
    partner_u.send_pcm(16'h001f, 160);
    ce <= 1'b1;
    rd(REG_ACF, d, r);
    chk("ce_freeze", d, 32'h0);
  endtask : t_enc

  // One frame with out-of-range and boundary lags, then playback
  task t_dec;
    logic [31:0] d;
    logic [1:0] r;
    logic [15:0] lag [4];
    logic [2:0] p;
    logic [31:0] e;
    int b, n, s, q;
    lag = '{16'd127, 16'd0, 16'd40, 16'd120};
    for (int i = 0; i < 8; i++) partner_u.frame[i] = 16'hffc0 | 16'(i);
    for (int i = 0; i < 4; i++) begin
      b = 8 + i * 17;
      partner_u.frame[b] = 16'hff80 | lag[i];
      partner_u.frame[b + 1] = 16'hfffd;
      partner_u.frame[b + 2] = 16'hfffe;
      partner_u.frame[b + 3] = 16'hffc5;
      for (int j = 0; j < 13; j++) begin
        partner_u.frame[b + 4 + j] = 16'hfff8 | 16'((i + j) % 8);
      end
    end
    partner_u.clear_got();
    wr(REG_CTRL, 32'h1, RESP_OK);
    partner_u.send_frame();
    if (partner_u.stalls != 0) begin
      num_errors++;
      wrap_up();
    end
    rd(REG_STATUS, d, r);
    chk("lag_flag", {24'h0, d[14:8], d[0]}, {24'h0, 7'd120, 1'b1});
    wr(REG_STATUS, 32'h1, RESP_OK);
    rd(REG_STATUS, d, r);
    chk("lag_clr", {31'h0, d[0]}, 32'h0);
    n = 0;
    while (partner_u.got_n < 160 && n < 4000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 4000) begin
      num_errors++;
      wrap_up();
    end
    for (int k = 0; k < 160; k++) begin
      s = k / 40;
      q = ((k % 40) / 3 > 12) ? 12 : (k % 40) / 3;
      p = 3'((s + q) % 8);
      e = {16'h0, ~p[2], p[1:0], 13'h0};
      chk("pcm_out", {16'h0, partner_u.got[k]}, e);
    end
  endtask : t_dec

  initial begin
    rst_n_i = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    ce = 1'b1;
    num_errors = 0;
    total_checks = 0;
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_regs();
    t_cmp();
    t_rc();
    t_enc();
    t_dec();
    wrap_up();
  end
endmodule : spc_core_tb
